// file: rtl/cfgp_defs.svh
// Constants of the configuration register host port
`ifndef CFGP_DEFS_SVH
`define CFGP_DEFS_SVH

// ==========================================================
// Bus and register file geometry
`define CFGP_BUS_W      10
`define CFGP_IDX_W      5
`define CFGP_DEPTH      32

// ==========================================================
// Reset and idle values
`define CFGP_CFG_RST    10'h000
`define CFGP_ADDR_RST   5'h00
`define CFGP_BUS_RST    10'h000
// Pattern driven when read strobe is low without select
`define CFGP_JUNK_VAL   10'h2AA

`endif

// file: rtl/cfgp_pkg.sv
// Types of the configuration register host port
package cfgp_pkg;
  `include "cfgp_defs.svh"

  typedef logic [`CFGP_BUS_W-1:0] cfgp_word_t;
  typedef logic [`CFGP_IDX_W-1:0] cfgp_idx_t;

  typedef enum logic {
    CFGP_SEQ_ADDR,
    CFGP_SEQ_DATA
  } cfgp_seq_t;
endpackage

// file: rtl/cfgp_strobe_edge.sv
// Falling edge detector for the active low host strobes
`timescale 1ns/10ps
module cfgp_strobe_edge (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  // Strobes, index 0 read, index 1 write
  input  wire logic [1:0] strobe_b_i,
  output logic      [1:0] fall_o
);
  logic [1:0] prev_q;
  logic [1:0] prev_d;

  always_comb begin
    prev_d = strobe_b_i;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_q <= 2'h3;
    end else begin
      prev_q <= prev_d;
    end
  end

  // ==========================================================
  // One pulse per strobe assertion
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_edge
      assign fall_o[g] = prev_q[g] & ~strobe_b_i[g];
    end
  endgenerate
endmodule

// file: rtl/cfgp_host_port.sv
// Configuration register host port: address/data write sequencer and shared bus driver
`timescale 1ns/10ps
`include "cfgp_defs.svh"
// Operation
// - Register reads and writes are accepted only while the select input is low; the host also strobes with select high.
// - Read strobe low with select and line scan low drives the addressed register onto the shared bus.
// - Every read strobe returns the write sequencer to its address state.
// - Read strobe low while select is high still drives the shared bus, with a meaningless pattern unless pixel data is selected.
// - A write strobe with select low takes the shared bus value into the port logic.
// - The first write of a sequence is the register address, latched for later reads and writes.
// - The second write of a sequence is stored into the register at the latched address.
// - Register writes work whatever the line scan state.
// - During line scan with pixel read low the bus carries pixel data and never register data.
module cfgp_host_port
  import cfgp_pkg::*;
(
  // Clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            rst_b_i,
  // Host strobes
  input  wire logic            reg_select_b_i,
  input  wire logic            read_strobe_b_i,
  input  wire logic            write_strobe_b_i,
  input  wire logic            pixel_read_b_i,
  // Scan state and pixel source
  input  wire logic            line_scan_active_i,
  input  wire cfgp_pkg::cfgp_word_t pixel_data_i,
  // Shared data bus pin
  input  wire cfgp_pkg::cfgp_word_t shared_data_bus_i,
  output cfgp_pkg::cfgp_word_t shared_data_bus_o,
  output logic                 shared_data_bus_oe_b_o,
  // Write notification to the core
  output logic                 cfg_wr_en_o,
  output cfgp_pkg::cfgp_idx_t  cfg_wr_addr_o,
  output cfgp_pkg::cfgp_word_t cfg_wr_data_o
);
  import cfgp_pkg::*;

  // ==========================================================
  // Strobe edges
  logic [1:0] fall;
  logic       rd_fall;
  logic       wr_fall;

  cfgp_strobe_edge u_edge (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .strobe_b_i ({write_strobe_b_i, read_strobe_b_i}),
    .fall_o     (fall)
  );

  assign rd_fall = fall[0];
  assign wr_fall = fall[1];

  // ==========================================================
  // Sequencer and register file
  cfgp_seq_t  seq_q;
  cfgp_seq_t  seq_d;
  cfgp_idx_t  addr_q;
  cfgp_idx_t  addr_d;
  logic       wen_d;
  logic       wen_q;
  cfgp_idx_t  waddr_q;
  cfgp_word_t wdata_q;
  cfgp_word_t wdata_d;
  cfgp_word_t cfg_mem [`CFGP_DEPTH];
  cfgp_word_t rd_val;

  assign rd_val = cfg_mem[addr_q];

  always_comb begin
    seq_d   = seq_q;
    addr_d  = addr_q;
    wen_d   = 1'b0;
    wdata_d = wdata_q;
    // Writes ignore scan state
    if (wr_fall && !reg_select_b_i) begin
      if (seq_q == CFGP_SEQ_ADDR) begin
        // Upper bus bits fall outside the register file
        addr_d = shared_data_bus_i[`CFGP_IDX_W-1:0];
        seq_d  = CFGP_SEQ_DATA;
      end else begin
        wen_d   = 1'b1;
        wdata_d = shared_data_bus_i;
        seq_d   = CFGP_SEQ_ADDR;
      end
    end
    // A read in the same cycle as a write still returns the sequencer to its address state
    if (rd_fall) begin
      seq_d = CFGP_SEQ_ADDR;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seq_q   <= CFGP_SEQ_ADDR;
      addr_q  <= `CFGP_ADDR_RST;
      wen_q   <= 1'b0;
      waddr_q <= `CFGP_ADDR_RST;
      wdata_q <= `CFGP_CFG_RST;
    end else begin
      seq_q   <= seq_d;
      addr_q  <= addr_d;
      wen_q   <= wen_d;
      waddr_q <= addr_q;
      wdata_q <= wdata_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `CFGP_DEPTH; i++) begin
        cfg_mem[i] <= `CFGP_CFG_RST;
      end
    end else if (wen_d) begin
      cfg_mem[addr_q] <= wdata_d;
    end
  end

  assign cfg_wr_en_o   = wen_q;
  assign cfg_wr_addr_o = waddr_q;
  assign cfg_wr_data_o = wdata_q;

  // ==========================================================
  // Shared bus driver
  cfgp_word_t bus_d;
  cfgp_word_t bus_q;
  logic       oe_b_d;
  logic       oe_b_q;
  logic       pix_sel;

  assign pix_sel = line_scan_active_i && !pixel_read_b_i;

  always_comb begin
    bus_d  = bus_q;
    oe_b_d = 1'b1;
    if (pix_sel) begin
      bus_d  = pixel_data_i;
      oe_b_d = 1'b0;
    end else if (!read_strobe_b_i && reg_select_b_i) begin
      // Host fault case; driving keeps contention visible on the pins
      bus_d  = `CFGP_JUNK_VAL;
      oe_b_d = 1'b0;
    end else if (!read_strobe_b_i && !line_scan_active_i) begin
      bus_d  = rd_val;
      oe_b_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_q  <= `CFGP_BUS_RST;
      oe_b_q <= 1'b1;
    end else begin
      bus_q  <= bus_d;
      oe_b_q <= oe_b_d;
    end
  end

  assign shared_data_bus_o      = bus_q;
  assign shared_data_bus_oe_b_o = oe_b_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_reg_read;
    (!read_strobe_b_i && !reg_select_b_i && !line_scan_active_i)
      |=> (!shared_data_bus_oe_b_o && shared_data_bus_o == $past(rd_val));
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("register read not driven");

  property p_rd_reset;
    rd_fall |=> seq_q == CFGP_SEQ_ADDR;
  endproperty
  a_rd_reset: assert property (p_rd_reset) else $error("read did not reset sequencer");

  property p_junk;
    (!read_strobe_b_i && reg_select_b_i && !pix_sel) |=> !shared_data_bus_oe_b_o;
  endproperty
  a_junk: assert property (p_junk) else $error("unselected read left bus floating");

  property p_addr_latch;
    (wr_fall && !reg_select_b_i && !rd_fall && seq_q == CFGP_SEQ_ADDR)
      |=> (seq_q == CFGP_SEQ_DATA && addr_q == $past(shared_data_bus_i[`CFGP_IDX_W-1:0]));
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

  property p_data_store;
    (wr_fall && !reg_select_b_i && seq_q == CFGP_SEQ_DATA)
      |=> (cfg_wr_en_o && cfg_wr_addr_o == $past(addr_q)
           && cfg_wr_data_o == $past(shared_data_bus_i));
  endproperty
  a_data_store: assert property (p_data_store) else $error("data write lost");

  property p_nosel;
    (wr_fall && reg_select_b_i && !rd_fall)
      |=> (seq_q == $past(seq_q) && addr_q == $past(addr_q) && !cfg_wr_en_o);
  endproperty
  a_nosel: assert property (p_nosel) else $error("write taken without select");

  property p_scan_write;
    (line_scan_active_i && wr_fall && !reg_select_b_i && seq_q == CFGP_SEQ_DATA) |=> cfg_wr_en_o;
  endproperty
  a_scan_write: assert property (p_scan_write) else $error("write blocked by scan");

  property p_pixel;
    pix_sel |=> (!shared_data_bus_oe_b_o && shared_data_bus_o == $past(pixel_data_i));
  endproperty
  a_pixel: assert property (p_pixel) else $error("pixel data not on bus");

  property p_idle;
    (read_strobe_b_i && !pix_sel) |=> shared_data_bus_oe_b_o;
  endproperty
  a_idle: assert property (p_idle) else $error("bus driven while idle");

  c_write_pair: cover property (wr_fall && seq_q == CFGP_SEQ_DATA ##1 cfg_wr_en_o);
  c_reg_read:   cover property (!read_strobe_b_i && !reg_select_b_i && !line_scan_active_i);
  c_pixel:      cover property (pix_sel ##1 !shared_data_bus_oe_b_o);
  c_junk:       cover property (!read_strobe_b_i && reg_select_b_i);
endmodule

// file: sim/cfgp_host_model.sv
// Host controller model for the configuration register port
`timescale 1ns/10ps
module cfgp_host_model
  import cfgp_pkg::*;
(
  // Clock
  input  wire logic       ref_clk_i,
  // Strobes and bus drive
  output logic            sel_b_o,
  output logic            rd_b_o,
  output logic            wr_b_o,
  output cfgp_word_t      bus_o
);
  initial begin
    sel_b_o = 1'b1;
    rd_b_o  = 1'b1;
    wr_b_o  = 1'b1;
    bus_o   = 10'h155;
  end

  // ==========================================================
  // Write pulse, strobe high for one edge before the next
  task automatic write_word(input cfgp_word_t v, input logic sb);
    @(negedge ref_clk_i);
    sel_b_o = sb;
    wr_b_o  = 1'b0;
    bus_o   = v;
    @(negedge ref_clk_i);
    wr_b_o  = 1'b1;
    sel_b_o = 1'b1;
    // Released bus must not keep the old value
    bus_o   = ~v;
  endtask

  // Select holds the sb level for the whole read strobe
  task automatic read_start(input logic sb);
    @(negedge ref_clk_i);
    sel_b_o = sb;
    rd_b_o  = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask

  task automatic read_end;
    rd_b_o  = 1'b1;
    sel_b_o = 1'b1;
  endtask
endmodule

// file: sim/test_config_register_host_port.sv
// Self-checking bench of the configuration register host port
`timescale 1ns/10ps
`include "cfgp_defs.svh"
module test_config_register_host_port;
  import cfgp_pkg::*;
  logic       ref_clk_i, rst_b_i, scan, pix_b, sel_b, rd_b, wr_b, oe_b, wr_en;
  cfgp_word_t pixel, host_bus, bus_i, bus_o, wr_data, a, b, d;
  cfgp_word_t mem [32];
  cfgp_idx_t  wr_addr;
  int         failures, num_checks;

  // Device drive wins on the shared pins
  assign bus_i = oe_b ? host_bus : bus_o;

  cfgp_host_port u_cfgp_host_port (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .reg_select_b_i(sel_b), .read_strobe_b_i(rd_b), .write_strobe_b_i(wr_b),
    .pixel_read_b_i(pix_b), .line_scan_active_i(scan), .pixel_data_i(pixel),
    .shared_data_bus_i(bus_i), .shared_data_bus_o(bus_o), .shared_data_bus_oe_b_o(oe_b),
    .cfg_wr_en_o(wr_en), .cfg_wr_addr_o(wr_addr), .cfg_wr_data_o(wr_data));

  cfgp_host_model u_cfgp_host_model (.ref_clk_i(ref_clk_i), .sel_b_o(sel_b),
    .rd_b_o(rd_b), .wr_b_o(wr_b), .bus_o(host_bus));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================
  // Checking helpers
  task automatic chk(input cfgp_word_t got, input cfgp_word_t exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic cfgp_word_t exp_bus(input logic sb, input cfgp_idx_t ix);
    if (scan && !pix_b) return pixel;
    if (sb) return `CFGP_JUNK_VAL;
    return mem[ix];
  endfunction

  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic pair_chk(input cfgp_word_t ad, input cfgp_word_t dt);
    u_cfgp_host_model.write_word(ad, 1'b0);
    u_cfgp_host_model.write_word(dt, 1'b0);
    // Notify pulse rose at the edge that took the data write
    chk(10'(wr_en), 10'h001);
    chk(10'(wr_addr), 10'(ad[4:0]));
    chk(wr_data, dt);
    mem[ad[4:0]] = dt;
    @(negedge ref_clk_i);
    chk(10'(wr_en), 10'h000);
  endtask

  task automatic rd_chk(input logic sb, input cfgp_idx_t ix, input logic oe_exp);
    u_cfgp_host_model.read_start(sb);
    chk(10'(oe_b), 10'(oe_exp));
    if (!oe_exp) chk(bus_o, exp_bus(sb, ix));
    u_cfgp_host_model.read_end();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_b_i = 1'b0;
    scan = 1'b0;
    pix_b = 1'b1;
    pixel = 10'h000;
    failures = 0;
    num_checks = 0;
    foreach (mem[i]) mem[i] = 10'h000;
    void'($urandom(33));
    repeat (16) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    chk(10'(oe_b), 10'h001);
    for (int i = 0; i < 24; i++) begin
      a = 10'($urandom);
      b = (i == 0) ? 10'h3FF : 10'($urandom);
      d = (i == 1) ? 10'h000 : 10'($urandom);
      scan = 1'($urandom);
      // Stray address write, then a read restarts the pair
      u_cfgp_host_model.write_word(a, 1'b0);
      scan = 1'b0;
      rd_chk(1'b0, a[4:0], 1'b0);
      scan = 1'($urandom);
      pair_chk(b, d);
    end
    // Unselected write is ignored, pairing unchanged
    u_cfgp_host_model.write_word(10'h3C5, 1'b1);
    pair_chk(10'h011, 10'h2D4);
    rd_chk(1'b1, 5'h00, 1'b0);
    scan = 1'b1;
    rd_chk(1'b0, 5'h11, 1'b1);
    pix_b = 1'b0;
    pixel = 10'($urandom);
    rd_chk(1'b0, 5'h11, 1'b0);
    complete_run();
  end

  initial begin
    #400000;
    failures++;
    complete_run();
  end
endmodule
